/* File: afs_pkg.sv */
// constants shared by the address/frame/shift executor and its shifter
// assumes a 32-bit Avalon-MM master that uses byte addresses, one word per register
package afs_pkg;
    // register byte offsets
    localparam logic [5:0] OFF_CTRL      = 6'h00;
    localparam logic [5:0] OFF_OPCODE    = 6'h04;
    localparam logic [5:0] OFF_EXT       = 6'h08;
    localparam logic [5:0] OFF_EFF_ADDR  = 6'h0C;
    localparam logic [5:0] OFF_OPERAND   = 6'h10;
    localparam logic [5:0] OFF_COUNT_SRC = 6'h14;
    localparam logic [5:0] OFF_STACK_PTR = 6'h18;
    localparam logic [5:0] OFF_PTR_REG   = 6'h1C;
    localparam logic [5:0] OFF_RESULT    = 6'h20;
    localparam logic [5:0] OFF_FLAGS     = 6'h24;
    localparam logic [5:0] OFF_PUSH_ADDR = 6'h28;
    localparam logic [5:0] OFF_PUSH_DATA = 6'h2C;
    // control / status bit positions
    localparam int CTRL_START_BIT  = 0;
    localparam int CTRL_CLRDONE_BIT = 1;
    localparam int STAT_BUSY_BIT   = 0;
    localparam int STAT_DONE_BIT   = 1;
    localparam int STAT_ILLEGAL_BIT = 2;
    // condition flag positions in the flags register
    localparam int FLAG_X = 4;
    localparam int FLAG_N = 3;
    localparam int FLAG_Z = 2;
    localparam int FLAG_V = 1;
    localparam int FLAG_C = 0;
    // reset values
    localparam logic [31:0] RST_WORD  = 32'h0000_0000;
    localparam logic [4:0]  RST_FLAGS = 5'h00;
    // opcode patterns
    localparam logic [3:0]  LDADR_TOP     = 4'h4;
    localparam logic [2:0]  LDADR_OPMODE  = 3'h7;
    localparam logic [12:0] LINK_W_PAT    = 13'h09CA;
    localparam logic [12:0] LINK_L_PAT    = 13'h0901;
    localparam logic [3:0]  SHIFT_TOP     = 4'hE;
    localparam logic [1:0]  SREG_TYPE     = 2'h1;
    localparam logic [2:0]  SMEM_TYPE     = 3'h1;
    localparam logic [1:0]  SIZE_BYTE     = 2'h0;
    localparam logic [1:0]  SIZE_WORD     = 2'h1;
    localparam logic [1:0]  SIZE_LONG     = 2'h2;
    localparam logic [1:0]  SIZE_MEMFORM  = 2'h3;
    // addressing mode codes
    localparam logic [2:0]  MODE_IND      = 3'h2;
    localparam logic [2:0]  MODE_POSTINC  = 3'h3;
    localparam logic [2:0]  MODE_PREDEC   = 3'h4;
    localparam logic [2:0]  MODE_DISP     = 3'h5;
    localparam logic [2:0]  MODE_INDEX    = 3'h6;
    localparam logic [2:0]  MODE_EXT      = 3'h7;
    localparam logic [2:0]  EXT_ABS_L     = 3'h1;
    localparam logic [2:0]  EXT_PC_INDEX  = 3'h3;
    // counts
    localparam logic [31:0] FRAME_SLOT    = 32'h0000_0004;
    localparam logic [5:0]  IMM_ZERO_CNT  = 6'h08;
    localparam logic [5:0]  MEM_CNT       = 6'h01;
    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_EXEC = 1'b1
    } afs_state_t;
endpackage : afs_pkg

/* File: afs_shifter.sv */
// logical shifter: byte/word/long operand, count 0..63, either direction
// purely combinational; the caller registers its outputs
module afs_shifter
    import afs_pkg::*;
#(
    parameter int WIDTH = 32
) (
    input  wire logic [WIDTH-1:0] value,
    input  wire logic [1:0]       size,
    input  wire logic [5:0]       count,
    input  wire logic             left,
    output logic      [WIDTH-1:0] result,
    output logic                  last_out,
    output logic                  sign
);
    if (WIDTH != 32) begin : g_width_check
        $error("afs_shifter supports WIDTH 32 only");
    end

    logic [WIDTH-1:0]   mask;
    logic [WIDTH-1:0]   masked;
    logic [3*WIDTH-1:0] left_wide;
    logic [WIDTH:0]     right_wide;
    logic [WIDTH-1:0]   shifted;
    logic               left_last;

    assign mask = (size == SIZE_BYTE) ? 32'h0000_00FF :
                  (size == SIZE_WORD) ? 32'h0000_FFFF : 32'hFFFF_FFFF;
    assign masked = value & mask;
    // left: the bit just above the operand's msb is the last one pushed out
    assign left_wide = {{(2*WIDTH){1'b0}}, masked} << count;
    assign left_last = (size == SIZE_BYTE) ? left_wide[8] :
                       (size == SIZE_WORD) ? left_wide[16] : left_wide[32];
    // right: a guard bit below bit 0 catches the last bit pushed out
    assign right_wide = {masked, 1'b0} >> count;
    assign shifted = left ? left_wide[WIDTH-1:0] : right_wide[WIDTH:1];
    // vacated positions are zero by construction, and the mask drops overflow
    assign result = shifted & mask;
    assign last_out = left ? left_last : right_wide[0];
    assign sign = (size == SIZE_BYTE) ? result[7] :
                  (size == SIZE_WORD) ? result[15] : result[31];
endmodule : afs_shifter

/* File: afs_exec_top.sv */
// executor for load-address, frame-allocate and logical shift instructions
// software loads opcode, extension words and operand values, then starts one execution
// Overview of operation
// - load-address writes all 32 effective address bits to pointer; flags untouched
// - load-address accepts only modes 010, 101, 110 and 111 control forms
// - frame-allocate: stack down 4, push pointer, pointer gets stack, add displacement
// - word displacement is sign-extended first extension word; long is high half first
// - logical shift loads carry with the last bit shifted out
// - immediate count field gives 1 to 7, and zero means eight
// - register count is the data register value modulo 64
// - memory shift moves one bit at word size; register shifts any size
// - left shift sends msb-out bits to carry and extend, fills zeros low
// - right shift sends lsb-out bits to carry and extend, fills zeros high
// - extend takes last bit out, but holds for a zero count
// - carry clears for a zero count
// - negative from sign at size, zero if result zero, overflow always cleared
// - direction bit 0 shifts right, 1 shifts left
// - size field 00 byte, 01 word, 10 long
// - count-source bit 0 immediate, 1 register; low three bits pick the register
// - memory shift accepts only memory alterable modes
//
// Chosen here: the register addresses and the Avalon-MM register port.
module afs_exec_top
    import afs_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic [5:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest
);
    import afs_pkg::*;

    afs_state_t  state;
    afs_state_t  next_state;
    logic [15:0] opcode;
    logic [31:0] ext;
    logic [31:0] eff_addr;
    logic [31:0] operand;
    logic [31:0] count_src;
    logic [31:0] stack_ptr;
    logic [31:0] ptr_reg;
    logic [31:0] result;
    logic [4:0]  flags;
    logic [31:0] push_addr;
    logic [31:0] push_data;
    logic        done;
    logic        illegal;

    // bus decode: each access is taken once, on the edge where waitrequest is high
    wire        req       = avs_read | avs_write;
    wire        accept    = req & avs_waitrequest;
    wire        wr_acc    = accept & avs_write;
    wire [31:0] be_mask   = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                             {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    wire        wr_ctrl   = wr_acc & (avs_address == OFF_CTRL);
    wire        start     = wr_ctrl & avs_byteenable[0] & avs_writedata[CTRL_START_BIT]
                            & (state == ST_IDLE);
    wire        clr_done  = wr_ctrl & avs_byteenable[0] & avs_writedata[CTRL_CLRDONE_BIT];

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [31:0] m);
        merge = (old & ~m) | (nw & m);
    endfunction : merge

    // only the low half lands: the opcode register is one instruction word wide
    wire [31:0] opcode_merged = merge({16'h0, opcode}, avs_writedata, be_mask);

    // instruction decode
    wire [2:0] ea_mode   = opcode[5:3];
    wire [2:0] ea_reg    = opcode[2:0];
    wire is_ldadr  = (opcode[15:12] == LDADR_TOP) && (opcode[8:6] == LDADR_OPMODE);
    wire is_link_w = (opcode[15:3] == LINK_W_PAT);
    wire is_link_l = (opcode[15:3] == LINK_L_PAT);
    wire is_link   = is_link_w | is_link_l;
    wire is_sreg   = (opcode[15:12] == SHIFT_TOP) && (opcode[4:3] == SREG_TYPE)
                     && (opcode[7:6] != SIZE_MEMFORM);
    wire is_smem   = (opcode[15:12] == SHIFT_TOP) && (opcode[11:9] == SMEM_TYPE)
                     && (opcode[7:6] == SIZE_MEMFORM);
    wire is_shift  = is_sreg | is_smem;
    wire ldadr_mode_ok = (ea_mode == MODE_IND) || (ea_mode == MODE_DISP)
                         || (ea_mode == MODE_INDEX)
                         || ((ea_mode == MODE_EXT) && (ea_reg <= EXT_PC_INDEX));
    wire mem_mode_ok = ((ea_mode >= MODE_IND) && (ea_mode <= MODE_INDEX))
                       || ((ea_mode == MODE_EXT) && (ea_reg <= EXT_ABS_L));
    wire op_ok = (is_ldadr & ldadr_mode_ok) | is_link | is_sreg | (is_smem & mem_mode_ok);

    // shift parameters
    wire       shift_left = opcode[8];
    wire [1:0] eff_size   = is_smem ? SIZE_WORD : opcode[7:6];
    wire [2:0] cnt_field  = opcode[11:9];
    wire [5:0] imm_cnt    = (cnt_field == 3'h0) ? IMM_ZERO_CNT : {3'h0, cnt_field};
    wire [5:0] reg_cnt    = count_src[5:0];
    wire [5:0] eff_count  = is_smem ? MEM_CNT : (opcode[5] ? reg_cnt : imm_cnt);
    wire [31:0] sh_result;
    wire        sh_last;
    wire        sh_sign;

    afs_shifter #(.WIDTH(32)) u_shifter (
        .value    (operand),
        .size     (eff_size),
        .count    (eff_count),
        .left     (shift_left),
        .result   (sh_result),
        .last_out (sh_last),
        .sign     (sh_sign)
    );

    // register destinations keep their bits above the operation size
    wire [31:0] size_mask = (eff_size == SIZE_BYTE) ? 32'h0000_00FF :
                            (eff_size == SIZE_WORD) ? 32'h0000_FFFF : 32'hFFFF_FFFF;
    wire [31:0] shift_out = merge(operand, sh_result, size_mask);
    wire        cnt_zero  = (eff_count == 6'h00);
    wire [4:0]  shift_flags;
    assign shift_flags[FLAG_X] = cnt_zero ? flags[FLAG_X] : sh_last;
    assign shift_flags[FLAG_N] = sh_sign;
    assign shift_flags[FLAG_Z] = (sh_result == 32'h0000_0000);
    assign shift_flags[FLAG_V] = 1'b0;
    assign shift_flags[FLAG_C] = cnt_zero ? 1'b0 : sh_last;

    // frame allocate
    wire [31:0] disp     = is_link_w ? {{16{ext[31]}}, ext[31:16]} : ext;
    wire [31:0] frame_top = stack_ptr - FRAME_SLOT;

    wire exec      = (state == ST_EXEC);
    wire do_ldadr  = exec & op_ok & is_ldadr;
    wire do_link   = exec & op_ok & is_link;
    wire do_shift  = exec & op_ok & is_shift;

    assign next_state = start ? ST_EXEC : ST_IDLE;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // software-loaded operands
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            opcode    <= RST_WORD[15:0];
            ext       <= RST_WORD;
            eff_addr  <= RST_WORD;
            operand   <= RST_WORD;
            count_src <= RST_WORD;
        end else if (wr_acc) begin
            if (avs_address == OFF_OPCODE)    opcode    <= opcode_merged[15:0];
            if (avs_address == OFF_EXT)       ext       <= merge(ext, avs_writedata, be_mask);
            if (avs_address == OFF_EFF_ADDR)  eff_addr  <= merge(eff_addr, avs_writedata,
                                                                 be_mask);
            if (avs_address == OFF_OPERAND)   operand   <= merge(operand, avs_writedata,
                                                                 be_mask);
            if (avs_address == OFF_COUNT_SRC) count_src <= merge(count_src, avs_writedata,
                                                                 be_mask);
        end
    end

    // architectural state: execution wins over a software write in the same cycle
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            stack_ptr <= RST_WORD;
            ptr_reg   <= RST_WORD;
            flags     <= RST_FLAGS;
        end else if (do_ldadr) begin
            ptr_reg <= eff_addr;
        end else if (do_link) begin
            ptr_reg   <= frame_top;
            stack_ptr <= frame_top + disp;
        end else if (do_shift) begin
            flags <= shift_flags;
        end else if (wr_acc) begin
            if (avs_address == OFF_STACK_PTR) stack_ptr <= merge(stack_ptr, avs_writedata,
                                                                 be_mask);
            if (avs_address == OFF_PTR_REG)   ptr_reg   <= merge(ptr_reg, avs_writedata,
                                                                 be_mask);
            if ((avs_address == OFF_FLAGS) && avs_byteenable[0]) begin
                flags <= avs_writedata[4:0];
            end
        end
    end

    // execution results and status; done set wins over a clear
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            result    <= RST_WORD;
            push_addr <= RST_WORD;
            push_data <= RST_WORD;
            done      <= 1'b0;
            illegal   <= 1'b0;
        end else begin
            if (do_shift) result <= shift_out;
            if (do_ldadr) result <= eff_addr;
            if (do_link) begin
                push_addr <= frame_top;
                push_data <= ptr_reg;
                result    <= frame_top;
            end
            if (exec) illegal <= ~op_ok;
            done <= exec | (done & ~clr_done);
        end
    end

    // read mux
    wire [31:0] status_word = {29'h0, illegal, done, exec};
    wire [31:0] rd_mux =
        (avs_address == OFF_CTRL)      ? status_word :
        (avs_address == OFF_OPCODE)    ? {16'h0, opcode} :
        (avs_address == OFF_EXT)       ? ext :
        (avs_address == OFF_EFF_ADDR)  ? eff_addr :
        (avs_address == OFF_OPERAND)   ? operand :
        (avs_address == OFF_COUNT_SRC) ? count_src :
        (avs_address == OFF_STACK_PTR) ? stack_ptr :
        (avs_address == OFF_PTR_REG)   ? ptr_reg :
        (avs_address == OFF_RESULT)    ? result :
        (avs_address == OFF_FLAGS)     ? {27'h0, flags} :
        (avs_address == OFF_PUSH_ADDR) ? push_addr :
        (avs_address == OFF_PUSH_DATA) ? push_data : 32'h0000_0000;

    // one wait cycle per access keeps both outputs registered
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= RST_WORD;
        end else begin
            avs_waitrequest <= ~accept;
            if (accept & avs_read) avs_readdata <= rd_mux;
        end
    end

    AST_LDADR_PTR: assert property (@(posedge clock) disable iff (rst)
        do_ldadr |=> (ptr_reg == $past(eff_addr)) && (result == ptr_reg))
        else $error("load-address did not write the full effective address");

    AST_LDADR_FLAGS: assert property (@(posedge clock) disable iff (rst)
        (exec && is_ldadr) |=> $stable(flags))
        else $error("load-address changed the flags");

    AST_LDADR_MODE: assert property (@(posedge clock) disable iff (rst)
        (exec && is_ldadr && (ea_mode == MODE_POSTINC)) |=> illegal && $stable(ptr_reg))
        else $error("load-address accepted a non-control mode");

    AST_LINK_W: assert property (@(posedge clock) disable iff (rst)
        (do_link && is_link_w) |=>
        stack_ptr == $past(stack_ptr) - 32'h4 + {{16{$past(ext[31])}}, $past(ext[31:16])})
        else $error("word frame-allocate stack pointer wrong");

    // long form: the whole extension register is the displacement, high half first
    AST_LINK_L: assert property (@(posedge clock) disable iff (rst)
        (do_link && is_link_l) |=> stack_ptr == $past(stack_ptr) - 32'h4 + $past(ext))
        else $error("long frame-allocate stack pointer wrong");

    AST_LINK_PUSH: assert property (@(posedge clock) disable iff (rst)
        do_link |=> (push_data == $past(ptr_reg)) && (ptr_reg == push_addr)
                    && (push_addr == $past(stack_ptr) - 32'h4) && $stable(flags))
        else $error("frame-allocate push or pointer copy wrong");

    // judged by the result, so a wrong count decode cannot vouch for itself
    AST_IMM8: assert property (@(posedge clock) disable iff (rst)
        (do_shift && is_sreg && !opcode[5] && (cnt_field == 3'h0) && !shift_left
         && (eff_size == SIZE_LONG)) |=> (result == ($past(operand) >> 8))
         && (flags[FLAG_C] == $past(operand[7])))
        else $error("immediate zero count is not eight");

    AST_REGCNT: assert property (@(posedge clock) disable iff (rst)
        (do_shift && is_sreg && opcode[5] && !shift_left && (eff_size == SIZE_LONG))
        |=> result == ($past(operand) >> $past(count_src[5:0])))
        else $error("register count not modulo 64");

    AST_MEM_ONE: assert property (@(posedge clock) disable iff (rst)
        do_shift && is_smem |=> result[15:0] == ($past(shift_left) ?
            {$past(operand[14:0]), 1'b0} : {1'b0, $past(operand[15:1])}))
        else $error("memory shift not one bit at word size");

    AST_ZERO_CNT: assert property (@(posedge clock) disable iff (rst)
        (do_shift && cnt_zero) |=> !flags[FLAG_C] && (flags[FLAG_X] == $past(flags[FLAG_X])))
        else $error("zero count flag handling wrong");

    AST_SHL_LONG: assert property (@(posedge clock) disable iff (rst)
        (do_shift && is_sreg && shift_left && (eff_size == SIZE_LONG) && (eff_count == 6'h01))
        |=> flags[FLAG_C] == $past(operand[31]) && flags[FLAG_X] == flags[FLAG_C]
            && !flags[FLAG_V])
        else $error("left shift carry or overflow wrong");

    AST_SHR_BYTE: assert property (@(posedge clock) disable iff (rst)
        (do_shift && is_sreg && !shift_left && (eff_size == SIZE_BYTE) && (eff_count == 6'h01))
        |=> flags[FLAG_C] == $past(operand[0]) && !result[7])
        else $error("right shift carry or fill wrong");

    // word size covers the memory form too, whose result sits in the low half
    AST_SHIFT_NZ: assert property (@(posedge clock) disable iff (rst)
        (do_shift && (eff_size == SIZE_WORD)) |=> (flags[FLAG_N] == result[15])
        && (flags[FLAG_Z] == (result[15:0] == 16'h0000)) && !flags[FLAG_V])
        else $error("word shift negative, zero or overflow flag wrong");

    // a refused opcode or mode must leave every architectural register alone
    AST_ILLEGAL_KEEP: assert property (@(posedge clock) disable iff (rst)
        (exec && !op_ok) |=> illegal && $stable(ptr_reg) && $stable(stack_ptr)
        && $stable(flags))
        else $error("refused operation changed architectural state");

    COV_LDADR: cover property (@(posedge clock) disable iff (rst) do_ldadr);
    COV_LINK_L: cover property (@(posedge clock) disable iff (rst) do_link && is_link_l);
    COV_SHIFT_MEM: cover property (@(posedge clock) disable iff (rst) do_shift && is_smem);
    COV_SHIFT_ZERO: cover property (@(posedge clock) disable iff (rst) do_shift && cnt_zero);
    COV_SHIFT_MOD: cover property (@(posedge clock) disable iff (rst)
        do_shift && is_sreg && opcode[5] && (count_src[7:6] != 2'h0));
endmodule : afs_exec_top

/* File: tb_addr_frame_shift_exec.sv */
// self-checking bench for the address/frame/shift executor, driven over its Avalon-MM port
// assumes execution ends one edge after start; the bus task waits out any latency
module tb_addr_frame_shift_exec;
    timeunit 1ns;
    timeprecision 100ps;
    import afs_pkg::*;

    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic [5:0]  avs_address = 6'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0]  avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    int          n_mismatch = 0;
    int          checks_done = 0;
    int          cycles = 0;
    localparam logic [31:0] OPV = 32'h8000_8081;
    localparam logic [5:0] EA_LIST [12] = '{6'h10, 6'h2B, 6'h34, 6'h38, 6'h39, 6'h19, 6'h22,
                                            6'h00, 6'h09, 6'h3A, 6'h3B, 6'h3C};
    localparam logic [31:0] CNT_LIST [6] = '{32'h0, 32'h1, 32'h10, 32'h20, 32'h45, 32'h3F};

    afs_exec_top u_afs_exec_top (
        .clock           (clock),
        .rst             (rst),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_byteenable  (avs_byteenable),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest)
    );

    always #12.5 clock = ~clock;

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop

    // a hung handshake ends here instead of spinning forever
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            $display("mismatch at %0t: timeout", $time);
            n_mismatch = n_mismatch + 1;
            report_and_stop();
        end
    end

    // one access; always leaves an idle cycle before the next request
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge clock);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= ~wr;
        do begin
            @(posedge clock);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask : bus

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic chk(input logic [5:0] a, input logic [31:0] exp, input logic [31:0] m);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        checks_done++;
        if ((q & m) !== (exp & m)) begin
            n_mismatch++;
            $display("mismatch at %0t: offset %h read %h expected %h", $time, a, q & m, exp & m);
        end
    endtask : chk

    // start one execution, check the status word, then clear done
    task automatic run(input logic [15:0] op, input logic ill);
        wr(OFF_OPCODE, {16'h0, op});
        wr(OFF_CTRL, 32'h1 << CTRL_START_BIT);
        chk(OFF_CTRL, (32'h1 << STAT_DONE_BIT) | (32'(ill) << STAT_ILLEGAL_BIT), 32'h7);
        wr(OFF_CTRL, 32'h1 << CTRL_CLRDONE_BIT);
    endtask : run

    // bench's own shift model: returns {X,N,Z,V,C, result}
    function automatic logic [36:0] shift_ref(input logic [31:0] v, input int w, input int cnt,
                                              input logic left, input logic xin);
        logic [31:0] m;
        logic [31:0] r;
        logic        last;
        m = (w == 32) ? 32'hFFFF_FFFF : ((32'h1 << w) - 32'h1);
        r = v & m;
        last = 1'b0;
        for (int i = 0; i < cnt; i++) begin
            last = left ? r[w-1] : r[0];
            r = left ? ((r << 1) & m) : (r >> 1);
        end
        return {(cnt != 0) ? last : xin, r[w-1], r == 32'h0, 1'b0,
                (cnt != 0) & last, (v & ~m) | r};
    endfunction : shift_ref

    task automatic shift_case(input logic [1:0] sz, input logic left, input logic isreg,
                              input logic [2:0] fld, input logic [31:0] creg);
        logic [36:0] e;
        int          w;
        int          cnt;
        w = (sz == SIZE_BYTE) ? 8 : (sz == SIZE_WORD) ? 16 : 32;
        cnt = isreg ? int'(creg[5:0]) : ((fld == 3'h0) ? 8 : int'(fld));
        e = shift_ref(OPV, w, cnt, left, 1'b1);
        wr(OFF_OPERAND, OPV);
        wr(OFF_COUNT_SRC, creg);
        wr(OFF_FLAGS, 32'h1F);
        run({SHIFT_TOP, fld, left, sz, isreg, SREG_TYPE, 3'h2}, 1'b0);
        chk(OFF_RESULT, e[31:0], 32'hFFFF_FFFF);
        chk(OFF_FLAGS, {27'h0, e[36:32]}, 32'h1F);
    endtask : shift_case

    task automatic link_case(input logic [15:0] op, input logic [31:0] ext,
                             input logic [31:0] stk, input logic [31:0] stk_new);
        wr(OFF_EXT, ext);
        wr(OFF_STACK_PTR, stk);
        wr(OFF_PTR_REG, 32'hAAAA_5555);
        wr(OFF_FLAGS, 32'h0A);
        run(op, 1'b0);
        chk(OFF_PUSH_ADDR, stk - FRAME_SLOT, 32'hFFFF_FFFF);
        chk(OFF_PUSH_DATA, 32'hAAAA_5555, 32'hFFFF_FFFF);
        chk(OFF_PTR_REG, stk - FRAME_SLOT, 32'hFFFF_FFFF);
        chk(OFF_STACK_PTR, stk_new, 32'hFFFF_FFFF);
        chk(OFF_FLAGS, 32'h0A, 32'h1F);
    endtask : link_case

    initial begin
        logic [36:0] e;
        logic        ok;
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        chk(OFF_CTRL, 32'h0, 32'h7);
        chk(OFF_FLAGS, {27'h0, RST_FLAGS}, 32'h1F);
        chk(OFF_STACK_PTR, RST_WORD, 32'hFFFF_FFFF);
        wr(6'h30, 32'hDEAD_BEEF);
        chk(6'h30, 32'h0, 32'hFFFF_FFFF);
        wr(OFF_RESULT, 32'h1234_5678);
        chk(OFF_RESULT, RST_WORD, 32'hFFFF_FFFF);
        // control modes for load-address, memory alterable modes for memory shifts
        for (int k = 0; k < 12; k++) begin
            ok = (k < 5) || (k == 9) || (k == 10);
            wr(OFF_PTR_REG, 32'h0);
            wr(OFF_EFF_ADDR, 32'h89AB_CDE0 + k);
            wr(OFF_FLAGS, 32'h1F);
            run({LDADR_TOP, 3'h5, LDADR_OPMODE, EA_LIST[k]}, ~ok);
            chk(OFF_PTR_REG, ok ? 32'h89AB_CDE0 + k : 32'h0, 32'hFFFF_FFFF);
            chk(OFF_FLAGS, 32'h1F, 32'h1F);
            ok = (k < 7);
            e = shift_ref(OPV, 16, 1, k[0], 1'b1);
            wr(OFF_OPERAND, OPV);
            run({SHIFT_TOP, SMEM_TYPE, k[0], SIZE_MEMFORM, EA_LIST[k]}, ~ok);
            if (ok) begin
                chk(OFF_RESULT, e[31:0], 32'h0000_FFFF);
            end
            chk(OFF_FLAGS, ok ? {27'h0, e[36:32]} : 32'h1F, 32'h1F);
        end
        link_case(16'h4E53, 32'hFFF0_1234, 32'h0000_1000, 32'h0000_0FEC);
        link_case(16'h480B, 32'h0001_8000, 32'h0000_2000, 32'h0001_9FFC);
        for (int s = 0; s < 3; s++) begin
            for (int d = 0; d < 2; d++) begin
                for (int f = 0; f < 8; f++) begin
                    shift_case(s[1:0], d[0], 1'b0, f[2:0], 32'h0);
                end
                for (int c = 0; c < 6; c++) begin
                    shift_case(s[1:0], d[0], 1'b1, 3'h3, CNT_LIST[c]);
                end
            end
        end
        report_and_stop();
    end
endmodule : tb_addr_frame_shift_exec
